//--- src/hbmss_pkg.sv
/*
 Package of the host bus mode and serial slave block: interface mode
 codes, strap bit positions, register offsets, frame constants, states.
 Assumes a byte-addressed internal memory with a 16-bit data port.
*/
`default_nettype none
package hbmss_pkg;
   // Widths
   localparam int ADDR_W = 8;
   localparam int WORD_W = 16;
   localparam int CNT_W  = 4;
   localparam int IDX_W  = 5;
   // Interface mode codes {iface_sel_hi, iface_sel_lo}
   localparam logic [1:0] MODE_MUX8_LATCH  = 2'h0;
   localparam logic [1:0] MODE_MUX16_LATCH = 2'h1;
   localparam logic [1:0] MODE_MUX8_ADDR   = 2'h2;
   localparam logic [1:0] MODE_NONMUX8     = 2'h3;
   // Serial strap bit positions on ad_in
   localparam int STRAP_IDLE   = 0;
   localparam int STRAP_PHASE  = 1;
   localparam int STRAP_SELPOL = 2;
   localparam int STRAP_SYNC   = 3;
   // Fast read register pair
   localparam logic [ADDR_W-1:0] FAST_READ_LOW  = 8'h04;
   localparam logic [ADDR_W-1:0] FAST_READ_HIGH = 8'h05;
   // Serial frame bytes
   localparam logic [7:0] SYNC_PAT_FIRST  = 8'hAA;
   localparam logic [7:0] SYNC_PAT_SECOND = 8'h55;
   localparam logic [7:0] NO_PATTERN      = 8'h00;
   localparam logic [7:0] RESYNC_BYTE     = 8'hFF;
   localparam int CTRL_DIR_BIT = 7;
   localparam int CTRL_CNT_MSB = 3;
   // Byte index of the control byte and of the first data byte
   localparam logic [IDX_W-1:0] IDX_CTRL  = 5'h01;
   localparam logic [IDX_W-1:0] IDX_DATA  = 5'h02;
   localparam logic [IDX_W-1:0] IDX_IDLE  = 5'h1F;
   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [7:0]        BYTE_RST = 8'h00;
   typedef enum logic [2:0] {
      S_ADDR, S_CTRL, S_DATA, S_DONE, S_LOST
   } hbmss_ser_state_type;
   typedef enum logic [1:0] {
      P_IDLE, P_WAIT, P_HOLD
   } hbmss_par_state_type;
endpackage : hbmss_pkg
`default_nettype wire

//--- src/hbmss_top.sv
/*
 Host bus mode and serial slave: latches the host interface mode at
 reset, runs the four parallel bus modes or the serial slave, and
 reaches the internal memory over a one-cycle-latency port.
 Assumes mem_rdata is valid the cycle after mem_rd; sclk comes from the
 serial master; strap pins are stable around the reset release.
*/
// Notes on behaviour
// - Two mode straps pick four parallel modes
// - Straps zero, strobes low selects serial mode
// - Mode captured at reset release only
// - Latch-strobe modes drive ready wait states
// - Non-multiplexed: address on AD, data on port1
// - Reads copy data into fast read pair
// - Serial side is slave, master drives clock
// - Bytes shift MSB first, eight clocks each
// - Select held whole frame; inactive blocks I/O
// - Sample rising, change falling by default
// - Frame: address, control, one to fifteen data
// - First byte address, second byte control
// - Return AAH,55H or 00H,00H during header
// - FFH control or address means next address
// - Serial straps captured; idle clock level
// - Phase strap picks sampling clock edge
// - Polarity strap picks select active level
// - Control: bit7 direction, bits3-0 count
// - Direction zero reads, one writes memory
// - Address increments per further data byte
// - Zero count loses sync until resync
// - Serial output floats while not selected
// - Read ignores input; reselect per frame
`default_nettype none
module hbmss_top (
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       iface_sel_lo,
   input  wire logic                       iface_sel_hi,
   input  wire logic                       rd_n,
   input  wire logic                       wr_n,
   input  wire logic                       ale,
   input  wire logic                       addr_strobe_in,
   input  wire logic                       e_strobe,
   input  wire logic                       read_write,
   input  wire logic                       chip_sel,
   input  wire logic [hbmss_pkg::WORD_W-1:0] ad_in,
   output logic [hbmss_pkg::WORD_W-1:0]    ad_out,
   output logic                            ad_oe_n,
   input  wire logic [7:0]                 port1_in,
   output logic [7:0]                      port1_out,
   output logic                            port1_oe_n,
   output logic                            ready,
   output logic                            transfer_ack_n,
   input  wire logic                       sclk,
   input  wire logic                       mosi,
   output logic                            miso,
   output logic                            miso_oe_n,
   output logic [hbmss_pkg::ADDR_W-1:0]    mem_addr,
   output logic [hbmss_pkg::WORD_W-1:0]    mem_wdata,
   output logic [1:0]                      mem_be,
   output logic                            mem_wr,
   output logic                            mem_rd,
   input  wire logic [hbmss_pkg::WORD_W-1:0] mem_rdata,
   output logic                            serial_mode,
   output logic [1:0]                      iface_mode,
   output logic                            sync_lost
);
   import hbmss_pkg::*;

   localparam int PIN_W = 2 * WORD_W + 17;

   function automatic logic [7:0] lane_pick(
      input logic [WORD_W-1:0] w,
      input logic              a0);
      lane_pick = a0 ? w[15:8] : w[7:0];
   endfunction : lane_pick

   function automatic logic [1:0] lane_be(input logic a0);
      lane_be = a0 ? 2'h2 : 2'h1;
   endfunction : lane_be

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [PIN_W-1:0]  pin_s1_r;
   logic [PIN_W-1:0]  pin_s2_r;
   logic [WORD_W-1:0] ad_s;
   logic [7:0]        p1_s;
   logic [WORD_W-1:0] pad_unused;
   logic              rd_n_s;
   logic              wr_n_s;
   logic              ale_s;
   logic              as_s;
   logic              e_s;
   logic              rw_s;
   logic              cs_s;
   logic              sel_lo_s;
   logic              sel_hi_s;

   always_ff @(posedge sys_clk) begin
      pin_s1_r <= {ad_in, port1_in, {WORD_W{1'b0}}, rd_n, wr_n, ale,
                   addr_strobe_in, e_strobe, read_write, chip_sel,
                   iface_sel_lo, iface_sel_hi};
      pin_s2_r <= pin_s1_r;
   end

   assign {ad_s, p1_s, pad_unused, rd_n_s, wr_n_s, ale_s, as_s, e_s,
           rw_s, cs_s, sel_lo_s, sel_hi_s} = pin_s2_r;

   ////////////////////////////////////////////////////////////////////
   // Mode and strap capture
   logic       cap_done_r;
   logic       serial_r;
   logic [1:0] mode_r;
   logic       idle_hi_r;
   logic       phase_r;
   logic       selpol_r;
   logic       sync_en_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cap_done_r <= 1'b0;
         serial_r   <= 1'b0;
         mode_r     <= MODE_MUX8_LATCH;
         idle_hi_r  <= 1'b0;
         phase_r    <= 1'b0;
         selpol_r   <= 1'b0;
         sync_en_r  <= 1'b0;
      end else if (!cap_done_r) begin
         cap_done_r <= 1'b1;
         mode_r     <= {sel_hi_s, sel_lo_s};
         serial_r   <= !sel_hi_s && !sel_lo_s && !rd_n_s && !wr_n_s;
         idle_hi_r  <= ad_s[STRAP_IDLE];
         phase_r    <= ad_s[STRAP_PHASE];
         selpol_r   <= ad_s[STRAP_SELPOL];
         sync_en_r  <= ad_s[STRAP_SYNC];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Serial link domain (straps are static after capture)
   logic             link_clk;
   logic             sel_act;
   logic [2:0]       bit_cnt_r;
   logic [6:0]       in_sh_r;
   logic [IDX_W-1:0] byte_idx_r;
   logic [IDX_W-1:0] end_idx_r;
   logic [7:0]       rx_byte_r;
   logic             rx_tgl_r;
   logic [6:0]       tx_sh_r;
   logic             miso_r;
   logic [7:0]       in_byte;
   logic [7:0]       next_tx;
   logic [7:0]       tx_hold_r;

   assign link_clk = sclk ^ (idle_hi_r ^ phase_r);
   assign sel_act  = serial_r && (chip_sel == selpol_r);
   assign miso_oe_n = !sel_act;
   // Pattern MSB stands before the first edge
   assign miso      = (bit_cnt_r == 3'h0 && byte_idx_r == '0) ?
                      next_tx[7] : miso_r;
   assign in_byte   = {in_sh_r, mosi};

   // Sample on the rising link edge
   always_ff @(posedge link_clk or negedge sel_act) begin
      if (!sel_act) begin
         bit_cnt_r  <= 3'h0;
         in_sh_r    <= 7'h00;
         byte_idx_r <= '0;
         end_idx_r  <= IDX_IDLE;
      end else begin
         in_sh_r   <= {in_sh_r[5:0], mosi};
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == 3'h7) begin
            if (in_byte == RESYNC_BYTE && byte_idx_r <= IDX_CTRL)
               byte_idx_r <= '0;
            else if (byte_idx_r != IDX_IDLE)
               byte_idx_r <= byte_idx_r + IDX_W'(1);
            if (byte_idx_r == IDX_CTRL && in_byte != RESYNC_BYTE)
               end_idx_r <= IDX_DATA +
                            IDX_W'(in_byte[CTRL_CNT_MSB:0]);
         end
      end
   end

   always_ff @(posedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_byte_r <= BYTE_RST;
         rx_tgl_r  <= 1'b0;
      end else if (sel_act && bit_cnt_r == 3'h7) begin
         rx_byte_r <= in_byte;
         rx_tgl_r  <= !rx_tgl_r;
      end
   end

   always_comb begin
      if (byte_idx_r == '0 || byte_idx_r >= end_idx_r)
         next_tx = sync_en_r ? SYNC_PAT_FIRST : NO_PATTERN;
      else if (byte_idx_r == IDX_CTRL)
         next_tx = sync_en_r ? SYNC_PAT_SECOND : NO_PATTERN;
      else
         next_tx = tx_hold_r;
   end

   // Change output on the falling link edge
   always_ff @(negedge link_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_sh_r <= 7'h00;
         miso_r  <= 1'b0;
      end else if (bit_cnt_r == 3'h1 && byte_idx_r == '0) begin
         // First byte of a frame restarts pattern
         miso_r  <= next_tx[6];
         tx_sh_r <= {next_tx[5:0], 1'b0};
      end else if (bit_cnt_r == 3'h0) begin
         miso_r  <= next_tx[7];
         tx_sh_r <= next_tx[6:0];
      end else begin
         miso_r  <= tx_sh_r[6];
         tx_sh_r <= {tx_sh_r[5:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Crossing of byte events and select into the system clock
   logic rx_s1_r;
   logic rx_s2_r;
   logic rx_s3_r;
   logic sel_s1_r;
   logic sel_s2_r;
   logic rx_ev;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_s1_r  <= 1'b0;
         rx_s2_r  <= 1'b0;
         rx_s3_r  <= 1'b0;
         sel_s1_r <= 1'b0;
         sel_s2_r <= 1'b0;
      end else begin
         rx_s1_r  <= rx_tgl_r;
         rx_s2_r  <= rx_s1_r;
         rx_s3_r  <= rx_s2_r;
         sel_s1_r <= sel_act;
         sel_s2_r <= sel_s1_r;
      end
   end

   assign rx_ev = rx_s2_r ^ rx_s3_r;

   ////////////////////////////////////////////////////////////////////
   // Serial frame decoder
   hbmss_ser_state_type ser_st_r;
   logic [ADDR_W-1:0]   addr_r;
   logic [ADDR_W-1:0]   fetch_r;
   logic [CNT_W-1:0]    cnt_r;
   logic                dir_r;
   logic [CNT_W-1:0]    rx_cnt;

   assign rx_cnt = rx_byte_r[CTRL_CNT_MSB:0];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ser_st_r <= S_ADDR;
         addr_r   <= '0;
         fetch_r  <= '0;
         cnt_r    <= '0;
         dir_r    <= 1'b0;
      end else if (!sel_s2_r && ser_st_r != S_LOST) begin
         ser_st_r <= S_ADDR;
      end else if (rx_ev) begin
         case (ser_st_r)
            S_ADDR: begin
               if (rx_byte_r != RESYNC_BYTE) begin
                  addr_r   <= rx_byte_r;
                  fetch_r  <= rx_byte_r + ADDR_W'(1);
                  ser_st_r <= S_CTRL;
               end
            end
            S_CTRL: begin
               if (rx_byte_r == RESYNC_BYTE)
                  ser_st_r <= S_ADDR;
               else if (rx_cnt == '0)
                  ser_st_r <= S_LOST;
               else begin
                  dir_r    <= rx_byte_r[CTRL_DIR_BIT];
                  cnt_r    <= rx_cnt;
                  ser_st_r <= S_DATA;
                  if (!rx_byte_r[CTRL_DIR_BIT])
                     fetch_r <= fetch_r + ADDR_W'(1);
               end
            end
            S_DATA: begin
               addr_r <= addr_r + ADDR_W'(1);
               if (!dir_r)
                  fetch_r <= fetch_r + ADDR_W'(1);
               cnt_r <= cnt_r - CNT_W'(1);
               if (cnt_r == CNT_W'(1))
                  ser_st_r <= S_DONE;
            end
            S_LOST: begin
               if (rx_byte_r == RESYNC_BYTE)
                  ser_st_r <= S_ADDR;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         sync_lost <= 1'b0;
      else
         sync_lost <= (ser_st_r == S_LOST);
   end

   ////////////////////////////////////////////////////////////////////
   // Parallel access detection
   hbmss_par_state_type par_st_r;
   logic [ADDR_W-1:0]   latch_r;
   logic [ADDR_W-1:0]   pa;
   logic                par_act;
   logic                par_rd;
   logic                fast_hit;

   always_comb begin
      par_act = 1'b0;
      par_rd  = 1'b0;
      pa      = latch_r;
      case (mode_r)
         MODE_MUX8_LATCH, MODE_MUX16_LATCH: begin
            par_act = !rd_n_s || !wr_n_s;
            par_rd  = !rd_n_s;
         end
         MODE_MUX8_ADDR: begin
            par_act = e_s;
            par_rd  = rw_s;
         end
         default: begin
            // Address from AD, strobe with select
            par_act = !cs_s && e_s;
            par_rd  = rw_s;
            pa      = ad_s[ADDR_W-1:0];
         end
      endcase
      par_act = par_act && !serial_r && cap_done_r;
   end

   assign fast_hit = par_rd &&
                     (pa == FAST_READ_LOW || pa == FAST_READ_HIGH);

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         latch_r <= '0;
      else if ((mode_r == MODE_MUX8_ADDR) ? as_s : ale_s)
         latch_r <= ad_s[ADDR_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////
   // Memory requests
   logic              req_rd;
   logic              req_wr;
   logic [ADDR_W-1:0] req_addr;
   logic [WORD_W-1:0] req_wd;
   logic [1:0]        req_be;
   logic              rd_pend_r;

   always_comb begin
      req_rd   = 1'b0;
      req_wr   = 1'b0;
      req_addr = fetch_r;
      req_wd   = {rx_byte_r, rx_byte_r};
      req_be   = lane_be(addr_r[0]);
      if (serial_r) begin
         if (rx_ev && sel_s2_r) begin
            case (ser_st_r)
               S_ADDR: begin
                  req_rd   = rx_byte_r != RESYNC_BYTE;
                  req_addr = rx_byte_r;
               end
               S_CTRL: req_rd = rx_byte_r[CTRL_DIR_BIT] == 1'b0 &&
                                rx_cnt != '0;
               S_DATA: begin
                  req_rd = !dir_r;
                  req_wr = dir_r;
                  if (dir_r)
                     req_addr = addr_r;
               end
               default: ;
            endcase
         end
      end else if (par_st_r == P_IDLE && par_act && !fast_hit) begin
         req_rd   = par_rd;
         req_wr   = !par_rd;
         req_addr = pa;
         if (mode_r == MODE_MUX16_LATCH) begin
            req_wd = ad_s;
            req_be = 2'h3;
         end else begin
            req_wd = (mode_r == MODE_NONMUX8) ? {p1_s, p1_s}
                                              : {ad_s[7:0], ad_s[7:0]};
            req_be = lane_be(pa[0]);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mem_rd    <= 1'b0;
         mem_wr    <= 1'b0;
         mem_addr  <= '0;
         mem_wdata <= WORD_RST;
         mem_be    <= 2'h0;
         rd_pend_r <= 1'b0;
      end else begin
         mem_rd    <= req_rd;
         mem_wr    <= req_wr;
         rd_pend_r <= mem_rd;
         if (req_rd || req_wr) begin
            mem_addr  <= req_addr;
            mem_wdata <= req_wd;
            mem_be    <= req_be;
         end
      end
   end

   // Serial read data held stable for the link while in use
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         tx_hold_r <= BYTE_RST;
      else if (rd_pend_r && serial_r)
         tx_hold_r <= lane_pick(mem_rdata, mem_addr[0]);
   end

   ////////////////////////////////////////////////////////////////////
   // Parallel access sequencer
   logic [7:0]        fast_lo_r;
   logic [7:0]        fast_hi_r;
   logic [WORD_W-1:0] rd_word;
   logic [WORD_W-1:0] fast_word;

   assign rd_word = (mode_r == MODE_MUX16_LATCH) ? mem_rdata :
                    {8'h00, lane_pick(mem_rdata, mem_addr[0])};
   assign fast_word = (mode_r == MODE_MUX16_LATCH) ?
                      {fast_hi_r, fast_lo_r} :
                      {8'h00, (pa == FAST_READ_HIGH) ? fast_hi_r
                                                    : fast_lo_r};

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         par_st_r       <= P_IDLE;
         fast_lo_r      <= BYTE_RST;
         fast_hi_r      <= BYTE_RST;
         ad_out         <= WORD_RST;
         port1_out      <= BYTE_RST;
         ad_oe_n        <= 1'b1;
         port1_oe_n     <= 1'b1;
         ready          <= 1'b1;
         transfer_ack_n <= 1'b1;
      end else begin
         case (par_st_r)
            P_IDLE: begin
               if (par_act) begin
                  if (fast_hit) begin
                     ad_out    <= fast_word;
                     port1_out <= fast_word[7:0];
                     par_st_r  <= P_HOLD;
                  end else if (par_rd) begin
                     ready    <= mode_r == MODE_MUX8_ADDR ||
                                 mode_r == MODE_NONMUX8;
                     par_st_r <= P_WAIT;
                  end else
                     par_st_r <= P_HOLD;
               end
            end
            P_WAIT: begin
               if (rd_pend_r) begin
                  fast_lo_r <= mem_rdata[7:0];
                  fast_hi_r <= mem_rdata[15:8];
                  ad_out    <= rd_word;
                  port1_out <= rd_word[7:0];
                  ready     <= 1'b1;
                  par_st_r  <= P_HOLD;
               end
            end
            P_HOLD: begin
               if (!par_act) begin
                  ad_oe_n        <= 1'b1;
                  port1_oe_n     <= 1'b1;
                  transfer_ack_n <= 1'b1;
                  par_st_r       <= P_IDLE;
               end else begin
                  ad_oe_n    <= !par_rd || mode_r == MODE_NONMUX8;
                  port1_oe_n <= !par_rd || mode_r != MODE_NONMUX8;
                  transfer_ack_n <= mode_r != MODE_NONMUX8;
               end
            end
            default: par_st_r <= P_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status outputs
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         serial_mode <= 1'b0;
         iface_mode  <= MODE_MUX8_LATCH;
      end else begin
         serial_mode <= serial_r;
         iface_mode  <= mode_r;
      end
   end

endmodule : hbmss_top
`default_nettype wire

//--- dv/hbmss_monitor.sv
/* Checker of hbmss_top ports: mode capture, waits, select, writes.
   Assumes straps stay stable around the reset release. */
`default_nettype none
module hbmss_monitor (
   input wire logic               sys_clk,
   input wire logic               sys_rst,
   input wire logic               iface_sel_lo,
   input wire logic               iface_sel_hi,
   input wire logic               rd_n,
   input wire logic               wr_n,
   input wire logic               chip_sel,
   input wire logic [hbmss_pkg::WORD_W-1:0] ad_in,
   input wire logic               ad_oe_n,
   input wire logic               port1_oe_n,
   input wire logic               ready,
   input wire logic               miso_oe_n,
   input wire logic               mem_wr,
   input wire logic               serial_mode,
   input wire logic [1:0]         iface_mode,
   input wire logic               sync_lost
);
   timeunit 1ns;
   timeprecision 100ps;
   import hbmss_pkg::*;
   logic [2:0] cnt_r;
   logic [4:0] cap_r;
   // Straps seen during reset, cycles since release
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_r <= 3'h0;
         cap_r <= {iface_sel_hi, iface_sel_lo, rd_n, wr_n, ad_in[STRAP_SELPOL]};
      end else if (cnt_r != 3'h7) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   mode_code_a: assert property (cnt_r >= 3'h4 |-> iface_mode == cap_r[4:3])
      else $error("interface mode differs from straps");
   serial_pick_a: assert property (cnt_r >= 3'h4 |->
      serial_mode == (cap_r[4:1] == 4'h0)) else $error("serial mode wrong");
   mode_stable_a: assert property (cnt_r >= 3'h5 |->
      $stable(serial_mode) && $stable(iface_mode)) else $error("mode moved");
   wait_nodata_a: assert property (!ready |-> ad_oe_n)
      else $error("bus driven during wait");
   ready_cause_a: assert property (!ready |-> !$past(rd_n, 2))
      else $error("wait without read strobe");
   serial_quiet_a: assert property (serial_mode |-> ad_oe_n && port1_oe_n)
      else $error("parallel bus driven in serial mode");
   sel_float_a: assert property (serial_mode |->
      miso_oe_n == (chip_sel ^ cap_r[0])) else $error("serial out enable");
   write_pulse_a: assert property (mem_wr |=> !mem_wr)
      else $error("write strobe longer than a cycle");
   lost_nowrite_a: assert property (sync_lost |-> !mem_wr && serial_mode)
      else $error("write while out of sync");
endmodule : hbmss_monitor
`default_nettype wire

//--- dv/hbmss_spi_master.sv
/* Serial master model: makes the link clock only inside frames.
   Assumes idle-low clock, sampling on the rising edge. */
`default_nettype none
module hbmss_spi_master (
   output logic       sclk,
   output logic       mosi,
   output logic       cs_n,
   input wire logic   miso,
   output logic [7:0] rx_byte,
   output logic       rx_stb
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {sclk, mosi, cs_n, rx_byte, rx_stb} = {3'b001, 9'h000};
   end
   // select per frame, data toggles on select and on release
   task sel(input logic on);
      #5 cs_n = !on;
      mosi = ~mosi;
      #5;
   endtask : sel
   task xfer(input logic [7:0] tx);
      for (int i = 7; i >= 0; i--) begin
         mosi = tx[i];
         #3 rx_byte[i] = miso;
         sclk = 1'b1;
         #3 sclk = 1'b0;
      end
      rx_stb = 1'b1;
      #1 rx_stb = 1'b0;
   endtask : xfer
endmodule : hbmss_spi_master
`default_nettype wire

//--- dv/hbmss_top_tb.sv
/* Bench of hbmss_top: serial frames, then two parallel reads.
   Assumes the package and design are compiled first. */
`default_nettype none
module hbmss_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import hbmss_pkg::*;
   logic sys_clk, sys_rst, iface_sel_lo, iface_sel_hi, rd_n, wr_n, ale;
   logic chip_sel, sclk, mosi, miso, miso_oe_n, miso_w, ad_oe_n, ready;
   logic mem_wr, mem_rd, serial_mode, sync_lost, rx_stb, port1_oe_n;
   logic as_in, e_in, rw_in;
   logic [15:0] ad_in, ad_out, mem_wdata, mem_rdata, w;
   logic [7:0]  mem_addr, rx_byte, p1_in, mem [256], d [3];
   logic [1:0]  mem_be, iface_mode;
   logic [8:0]  rq [$];
   logic [15:0] wq [$];
   logic [31:0] seed = 32;
   int err_total, n_tests;
   assign miso_w = miso_oe_n ? 1'b1 : miso;
   hbmss_top hbmss_top_inst (.sys_clk, .sys_rst, .iface_sel_lo,
      .iface_sel_hi, .rd_n, .wr_n, .ale, .addr_strobe_in(as_in),
      .e_strobe(e_in), .read_write(rw_in), .chip_sel, .ad_in, .ad_out,
      .ad_oe_n, .port1_in(p1_in), .port1_out(), .port1_oe_n, .ready,
      .transfer_ack_n(), .sclk, .mosi, .miso, .miso_oe_n, .mem_addr,
      .mem_wdata, .mem_be, .mem_wr, .mem_rd, .mem_rdata, .serial_mode,
      .iface_mode, .sync_lost);
   hbmss_spi_master partner_inst (.sclk, .mosi, .cs_n(chip_sel),
      .miso(miso_w), .rx_byte, .rx_stb);
   always #2 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xs
   task chk(input string s, input logic [7:0] ex, input logic [7:0] got);
      n_tests++;
      if (got !== ex) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", s, ex, got);
      end
   endtask : chk
   task automatic take(input logic [7:0] got);
      logic [8:0] e;
      e = rq.pop_front();
      if (e[8]) chk("result byte", e[7:0], got);
   endtask : take
   task send(input logic [7:0] b, input logic [8:0] e);
      rq.push_back(e);
      partner_inst.xfer(b);
   endtask : send
   task pread(input logic [7:0] a, input logic [7:0] x);
      rq.push_back({1'b1, x});
      ale <= 1'b1;
      ad_in <= {8'h00, a};
      repeat (3) @(posedge sys_clk);
      ale <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd_n <= 1'b0;
      for (int t = 0; t < 20 && ad_oe_n; t++) @(posedge sys_clk);
      rd_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask : pread
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   // Memory model answers one cycle after the request
   always @(posedge sys_clk) begin
      mem_rdata <= {mem[{mem_addr[7:1], 1'b1}], mem[{mem_addr[7:1], 1'b0}]};
      if (mem_wr) begin
         if (mem_be[0]) mem[{mem_addr[7:1], 1'b0}] <= mem_wdata[7:0];
         if (mem_be[1]) mem[{mem_addr[7:1], 1'b1}] <= mem_wdata[15:8];
         w = wq.pop_front();
         chk("write addr", w[15:8], mem_addr);
         chk("write data", w[7:0], mem_addr[0] ? mem_wdata[15:8] : mem_wdata[7:0]);
      end
   end
   always @(posedge rx_stb) take(rx_byte);
   always @(negedge ad_oe_n) #1 take(ad_out[7:0]);
   initial begin
      #30000;
      err_total++;
      $display("watchdog expired");
      stop_test();
   end
   initial begin
      {sys_clk, sys_rst, iface_sel_lo, iface_sel_hi, rd_n, wr_n, ale} = 7'h20;
      ad_in = 16'h0008;
      {as_in, e_in, rw_in} = 3'h1;
      p1_in = xs();
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("serial mode", {7'h0, serial_mode}, 8'h01);
      foreach (d[k]) d[k] = xs();
      partner_inst.sel(1'b1);
      send(8'h10, 9'h0);
      send(8'h83, 9'h0);
      foreach (d[k]) wq.push_back({8'h10 + 8'(k), d[k]});
      foreach (d[k]) send(d[k], 9'h0);
      partner_inst.sel(1'b0);
      repeat (10) @(posedge sys_clk);
      $display("test write frame done");
      partner_inst.sel(1'b1);
      send(8'h10, {1'b1, SYNC_PAT_FIRST});
      send(8'h03, {1'b1, SYNC_PAT_SECOND});
      foreach (d[k]) send(8'h00, {1'b1, d[k]});
      partner_inst.sel(1'b0);
      $display("test read frame done");
      partner_inst.sel(1'b1);
      send(8'h20, 9'h0);
      send(8'h00, 9'h0);
      partner_inst.sel(1'b0);
      repeat (10) @(posedge sys_clk);
      chk("sync lost", {7'h0, sync_lost}, 8'h01);
      partner_inst.sel(1'b1);
      repeat (16) send(RESYNC_BYTE, 9'h0);
      partner_inst.sel(1'b0);
      repeat (10) @(posedge sys_clk);
      chk("sync lost", {7'h0, sync_lost}, 8'h00);
      $display("test resync done");
      partner_inst.sel(1'b1);
      send(8'h30, 9'h0);
      partner_inst.sel(1'b0);
      partner_inst.sel(1'b1);
      send(8'h40, {1'b1, SYNC_PAT_FIRST});
      send(RESYNC_BYTE, {1'b1, SYNC_PAT_SECOND});
      send(8'h11, 9'h0);
      send(8'h01, 9'h0);
      send(8'h00, {1'b1, d[1]});
      partner_inst.sel(1'b0);
      $display("test readdress done");
      sys_rst <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("serial mode", {7'h0, serial_mode}, 8'h00);
      chk("iface mode", {6'h0, iface_mode}, {6'h0, MODE_MUX8_LATCH});
      pread(8'h10, d[0]);
      pread(FAST_READ_LOW, d[0]);
      chk("pending", 8'(rq.size()), 8'h00);
      $display("test parallel read done");
      stop_test();
   end
endmodule : hbmss_top_tb
bind hbmss_top hbmss_monitor hbmss_monitor_inst (.sys_clk, .sys_rst,
   .iface_sel_lo, .iface_sel_hi, .rd_n, .wr_n, .chip_sel, .ad_in, .ad_oe_n,
   .port1_oe_n, .ready, .miso_oe_n, .mem_wr, .serial_mode, .iface_mode,
   .sync_lost);
`default_nettype wire
